// *** verilog/icid_bank.sv ***
// APB read-only capability identification register bank.
`timescale 1ns/1ps
`default_nettype none
`include "icid_regs.svh"

module icid_bank #(
  parameter logic TABLES_FIXED = 1'b0,
  parameter logic QUEUES_FIXED = 1'b0,
  parameter logic RELATIVE_BASE = 1'b0,
  parameter logic MEMTYPE_OVR = 1'b0,
  parameter logic PERM_OVR = 1'b0,
  parameter logic [4:0] CMDQ_LOG = 5'h08,
  parameter logic [4:0] EVTQ_LOG = 5'h08,
  parameter logic [4:0] PRQ_LOG = 5'h08,
  parameter logic [4:0] SSID_W = 5'h00,
  parameter logic [5:0] SID_W = 6'h10,
  parameter logic VPAGE_PRESENT = 1'b0,
  parameter logic [9:0] VPAGE_OFS = 10'h000,
  parameter logic [1:0] BREAK_LEVEL = 2'h1,
  parameter logic RANGE_INV = 1'b1,
  parameter logic S2_ATTR = 1'b0,
  parameter logic PART_MON = 1'b0,
  parameter logic PAGE_REQ = 1'b0,
  parameter logic PASID_USE = 1'b0,
  parameter logic PAGE_HWATTR = 1'b0,
  parameter logic STAGE1 = 1'b1,
  parameter logic DESC_DISABLE = 1'b1,
  // Arbitrary value, carries no maker meaning
  parameter logic [31:0] IMPL_WORD = 32'h0000_0000,
  parameter logic [15:0] STALL_LIMIT = 16'h0010,
  parameter logic [1:0] VIRT_EXT = 2'h0,
  parameter logic G64 = 1'b1,
  parameter logic G16 = 1'b0,
  parameter logic G4 = 1'b1,
  parameter logic TT32 = 1'b0,
  parameter logic [2:0] OUT_SIZE = 3'h5
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Live stall count of pending stall records
  input wire logic [15:0] STALL_COUNT,
  // Stall admission allowed while under the limit
  output logic STALL_ROOM
);

  // ==========================================================================
  // Field clamping and coupling functions
  function automatic logic [4:0] clamp_qs(input logic [4:0] v);
    clamp_qs = (v > `ICID_QS_MAX) ? `ICID_QS_MAX : v;
  endfunction : clamp_qs

  // Large granule is forced on when 52-bit sizes are claimed
  function automatic logic need_g64(input logic [1:0] ve, input logic [2:0] os);
    need_g64 = (ve == `ICID_VEXT_52) || (os == `ICID_OSIZE_52);
  endfunction : need_g64

  // ==========================================================================
  // Constant field values after legality fixes
  logic preset_any;
  logic [4:0] ssid_w;
  logic [5:0] sid_w;
  logic [1:0] brk_lvl;
  logic had;
  logic g64;
  logic [2:0] out_sz;
  logic [1:0] va_ext;
  logic pasid_flag;
  icid_pkg::icid_word_t w_tqs;
  icid_pkg::icid_word_t w_vpo;
  icid_pkg::icid_word_t w_flv;
  icid_pkg::icid_word_t w_gas;

  // Fix-ups keep illegal parameter mixes from ever being reported
  assign preset_any = TABLES_FIXED | QUEUES_FIXED;
  assign ssid_w = (SSID_W > `ICID_SSID_MAX) ? `ICID_SSID_MAX : SSID_W;
  assign sid_w = (SID_W > `ICID_SID_MAX) ? `ICID_SID_MAX : SID_W;
  assign brk_lvl = (BREAK_LEVEL > `ICID_BRK_L2) ? `ICID_BRK_L2 : BREAK_LEVEL;
  assign had = STAGE1 & (DESC_DISABLE | PAGE_HWATTR);
  assign va_ext = (VIRT_EXT > `ICID_VEXT_52) ? `ICID_VEXT_52 : VIRT_EXT;
  assign out_sz = (OUT_SIZE == `ICID_OSIZE_RSVD) ? `ICID_OSIZE_52 : OUT_SIZE;
  assign g64 = G64 | need_g64(va_ext, out_sz);
  assign pasid_flag = PASID_USE & PAGE_REQ & (ssid_w != 5'h00);

  // First size register
  always_comb
  begin
    w_tqs = `ICID_ZERO32;
    w_tqs[`ICID_TQS_TABLES] = TABLES_FIXED;
    w_tqs[`ICID_TQS_QUEUES] = QUEUES_FIXED;
    w_tqs[`ICID_TQS_RELATIVE] = RELATIVE_BASE & preset_any;
    w_tqs[`ICID_TQS_TYPES] = MEMTYPE_OVR;
    w_tqs[`ICID_TQS_PERMS] = PERM_OVR;
    w_tqs[`ICID_TQS_CMDQ_HI:`ICID_TQS_CMDQ_LO] = clamp_qs(CMDQ_LOG);
    w_tqs[`ICID_TQS_EVTQ_HI:`ICID_TQS_EVTQ_LO] = clamp_qs(EVTQ_LOG);
    w_tqs[`ICID_TQS_PRQ_HI:`ICID_TQS_PRQ_LO] = clamp_qs(PRQ_LOG);
    w_tqs[`ICID_TQS_SSID_HI:`ICID_TQS_SSID_LO] = ssid_w;
    w_tqs[`ICID_TQS_SID_HI:`ICID_TQS_SID_LO] = sid_w;
  end

  // Virtual page offset register
  always_comb
  begin
    w_vpo = `ICID_ZERO32;
    w_vpo[`ICID_VPO_HI:`ICID_VPO_LO] = VPAGE_PRESENT ? VPAGE_OFS : 10'h000;
  end

  // Feature level register
  always_comb
  begin
    w_flv = `ICID_ZERO32;
    w_flv[`ICID_FLV_BRK_HI:`ICID_FLV_BRK_LO] = brk_lvl;
    w_flv[`ICID_FLV_RANGE] = RANGE_INV;
    w_flv[`ICID_FLV_S2ATTR] = S2_ATTR;
    w_flv[`ICID_FLV_PARTMON] = PART_MON;
    w_flv[`ICID_FLV_PASID] = pasid_flag;
    w_flv[`ICID_FLV_HWATTR] = PAGE_HWATTR & STAGE1;
    w_flv[`ICID_FLV_HAD] = had;
  end

  // Granule and address size register
  always_comb
  begin
    w_gas = `ICID_ZERO32;
    w_gas[`ICID_GAS_STALL_HI:`ICID_GAS_STALL_LO] = STALL_LIMIT;
    w_gas[`ICID_GAS_VEXT_HI:`ICID_GAS_VEXT_LO] = va_ext;
    w_gas[`ICID_GAS_G64] = g64;
    w_gas[`ICID_GAS_G16] = G16;
    w_gas[`ICID_GAS_G4] = G4 | TT32;
    w_gas[`ICID_GAS_OSIZE_HI:`ICID_GAS_OSIZE_LO] = out_sz;
  end

  // ==========================================================================
  // Address decode
  function automatic icid_pkg::icid_sel_t decode(input logic [11:0] a);
    case (a)
      `ICID_OFF_TQS: decode = icid_pkg::ICID_SEL_TQS;
      `ICID_OFF_VPO: decode = icid_pkg::ICID_SEL_VPO;
      `ICID_OFF_FLV: decode = icid_pkg::ICID_SEL_FLV;
      `ICID_OFF_IMP: decode = icid_pkg::ICID_SEL_IMP;
      `ICID_OFF_GAS: decode = icid_pkg::ICID_SEL_GAS;
      default: decode = icid_pkg::ICID_SEL_NONE;
    endcase
  endfunction : decode

  icid_pkg::icid_sel_t sel;
  icid_pkg::icid_word_t rdata_next;
  logic setup;

  assign sel = decode(PADDR);
  assign setup = PSEL & ~PENABLE;

  // Read mux; writes decode like reads, but the words are constants so they can never alter a value
  always_comb
  begin
    case (sel)
      icid_pkg::ICID_SEL_TQS: rdata_next = w_tqs;
      icid_pkg::ICID_SEL_VPO: rdata_next = w_vpo;
      icid_pkg::ICID_SEL_FLV: rdata_next = w_flv;
      icid_pkg::ICID_SEL_IMP: rdata_next = IMPL_WORD;
      icid_pkg::ICID_SEL_GAS: rdata_next = w_gas;
      default: rdata_next = `ICID_ZERO32;
    endcase
  end

  // ==========================================================================
  // APB answer: ready in the access cycle, one wait-free transfer
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PREADY <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
    end
  end

  // Read data latched at setup; writes return zero and do nothing
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PRDATA <= `ICID_ZERO32;
    end
    else if (setup)
    begin
      PRDATA <= PWRITE ? `ICID_ZERO32 : rdata_next;
    end
  end

  // Unmapped address flagged as error; writes to mapped registers are dropped silently
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PSLVERR <= 1'b0;
    end
    else if (setup)
    begin
      PSLVERR <= (sel == icid_pkg::ICID_SEL_NONE);
    end
    else
    begin
      PSLVERR <= 1'b0;
    end
  end

  // ==========================================================================
  // Stall admission: room is high while the count sampled at the previous edge is under the limit
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      STALL_ROOM <= 1'b0;
    end
    else
    begin
      STALL_ROOM <= (STALL_COUNT < STALL_LIMIT);
    end
  end

  // ==========================================================================
  // Assertions
  property p_rel_zero;
    @(posedge CLOCK) disable iff (!RSTN)
    !preset_any |-> !w_tqs[`ICID_TQS_RELATIVE];
  endproperty
  a_rel_zero: assert property (p_rel_zero) else $error("relative flag set without preset");

  property p_qs_max;
    @(posedge CLOCK) disable iff (!RSTN)
    w_tqs[`ICID_TQS_CMDQ_HI:`ICID_TQS_CMDQ_LO] <= `ICID_QS_MAX
      && w_tqs[`ICID_TQS_EVTQ_HI:`ICID_TQS_EVTQ_LO] <= `ICID_QS_MAX;
  endproperty
  a_qs_max: assert property (p_qs_max) else $error("queue size above limit");

  property p_prq_max;
    @(posedge CLOCK) disable iff (!RSTN)
    w_tqs[`ICID_TQS_PRQ_HI:`ICID_TQS_PRQ_LO] <= `ICID_QS_MAX;
  endproperty
  a_prq_max: assert property (p_prq_max) else $error("page queue size above limit");

  property p_id_width;
    @(posedge CLOCK) disable iff (!RSTN)
    w_tqs[`ICID_TQS_SSID_HI:`ICID_TQS_SSID_LO] <= `ICID_SSID_MAX
      && w_tqs[`ICID_TQS_SID_HI:`ICID_TQS_SID_LO] <= `ICID_SID_MAX;
  endproperty
  a_id_width: assert property (p_id_width) else $error("id width out of range");

  property p_had_hwattr;
    @(posedge CLOCK) disable iff (!RSTN)
    w_flv[`ICID_FLV_HWATTR] |-> w_flv[`ICID_FLV_HAD];
  endproperty
  a_had_hwattr: assert property (p_had_hwattr) else $error("page attr without disable flag");

  property p_granule;
    @(posedge CLOCK) disable iff (!RSTN)
    need_g64(w_gas[`ICID_GAS_VEXT_HI:`ICID_GAS_VEXT_LO],
      w_gas[`ICID_GAS_OSIZE_HI:`ICID_GAS_OSIZE_LO]) |-> w_gas[`ICID_GAS_G64];
  endproperty
  a_granule: assert property (p_granule) else $error("52-bit without large granule");

  sequence s_read_setup;
    PSEL && !PENABLE && !PWRITE && (sel == icid_pkg::ICID_SEL_GAS);
  endsequence

  property p_read_gas;
    @(posedge CLOCK) disable iff (!RSTN)
    s_read_setup |=> PREADY && (PRDATA == w_gas);
  endproperty
  a_read_gas: assert property (p_read_gas) else $error("wrong read data");

  sequence s_write_setup;
    PSEL && !PENABLE && PWRITE;
  endsequence

  property p_write_none;
    @(posedge CLOCK) disable iff (!RSTN)
    s_write_setup |=> PREADY && (PRDATA == `ICID_ZERO32) ##1 $stable(w_tqs) && $stable(w_flv);
  endproperty
  a_write_none: assert property (p_write_none) else $error("write had an effect");

  property p_stall;
    @(posedge CLOCK) disable iff (!RSTN)
    (STALL_COUNT >= STALL_LIMIT) |=> !STALL_ROOM;
  endproperty
  a_stall: assert property (p_stall) else $error("stall room above limit");

  // Answer timing and error qualification; a stuck ready would hang any master
  property p_ready_answer;
    @(posedge CLOCK) disable iff (!RSTN)
    setup |=> PREADY;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");

  property p_ready_pulse;
    @(posedge CLOCK) disable iff (!RSTN)
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_err_qual;
    @(posedge CLOCK) disable iff (!RSTN)
    PSLVERR |-> PREADY;
  endproperty
  a_err_qual: assert property (p_err_qual) else $error("error without ready");

  property p_unmapped;
    @(posedge CLOCK) disable iff (!RSTN)
    setup && (sel == icid_pkg::ICID_SEL_NONE) |=> PSLVERR && (PRDATA == `ICID_ZERO32);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  sequence s_read_tqs;
    PSEL && !PENABLE && !PWRITE && (sel == icid_pkg::ICID_SEL_TQS);
  endsequence

  property p_read_tqs;
    @(posedge CLOCK) disable iff (!RSTN)
    s_read_tqs |=> PREADY && (PRDATA == w_tqs);
  endproperty
  a_read_tqs: assert property (p_read_tqs) else $error("wrong size register data");

  sequence s_read_flv;
    PSEL && !PENABLE && !PWRITE && (sel == icid_pkg::ICID_SEL_FLV);
  endsequence

  property p_read_flv;
    @(posedge CLOCK) disable iff (!RSTN)
    s_read_flv |=> PREADY && (PRDATA == w_flv);
  endproperty
  a_read_flv: assert property (p_read_flv) else $error("wrong feature register data");

  property p_pasid_zero;
    @(posedge CLOCK) disable iff (!RSTN)
    (!PAGE_REQ || (ssid_w == 5'h00)) |-> !w_flv[`ICID_FLV_PASID];
  endproperty
  a_pasid_zero: assert property (p_pasid_zero) else $error("pasid flag without support");

  property p_had_stage1;
    @(posedge CLOCK) disable iff (!RSTN)
    !STAGE1 |-> !w_flv[`ICID_FLV_HAD] && !w_flv[`ICID_FLV_HWATTR];
  endproperty
  a_had_stage1: assert property (p_had_stage1) else $error("disable flag without stage 1");

  property p_out_size;
    @(posedge CLOCK) disable iff (!RSTN)
    w_gas[`ICID_GAS_OSIZE_HI:`ICID_GAS_OSIZE_LO] != `ICID_OSIZE_RSVD;
  endproperty
  a_out_size: assert property (p_out_size) else $error("reserved output size");

  property p_small_gran;
    @(posedge CLOCK) disable iff (!RSTN)
    TT32 |-> w_gas[`ICID_GAS_G4];
  endproperty
  a_small_gran: assert property (p_small_gran) else $error("small granule missing");

endmodule : icid_bank
`default_nettype wire

// *** verilog/icid_regs.svh ***
// Offsets, field positions and default values of the capability identification bank.
`ifndef ICID_REGS_SVH
`define ICID_REGS_SVH

// ==========================================================================
// Register byte offsets
`define ICID_OFF_TQS 12'h004
`define ICID_OFF_VPO 12'h008
`define ICID_OFF_FLV 12'h00c
`define ICID_OFF_IMP 12'h010
`define ICID_OFF_GAS 12'h014
`define ICID_OFF_MSB 11
`define ICID_ZERO32 32'h0000_0000

// ==========================================================================
// table_queue_size_id fields
`define ICID_TQS_TABLES 30
`define ICID_TQS_QUEUES 29
`define ICID_TQS_RELATIVE 28
`define ICID_TQS_TYPES 27
`define ICID_TQS_PERMS 26
`define ICID_TQS_CMDQ_HI 25
`define ICID_TQS_CMDQ_LO 21
`define ICID_TQS_EVTQ_HI 20
`define ICID_TQS_EVTQ_LO 16
`define ICID_TQS_PRQ_HI 15
`define ICID_TQS_PRQ_LO 11
`define ICID_TQS_SSID_HI 10
`define ICID_TQS_SSID_LO 6
`define ICID_TQS_SID_HI 5
`define ICID_TQS_SID_LO 0
`define ICID_QS_MAX 5'h13
`define ICID_SSID_MAX 5'h14
`define ICID_SID_MAX 6'h20

// ==========================================================================
// virtual_page_offset_id fields
`define ICID_VPO_HI 9
`define ICID_VPO_LO 0
`define ICID_VPAGE_BASE 32'h0002_0000
`define ICID_VPAGE_UNIT 32'h0001_0000

// ==========================================================================
// feature_level_id fields
`define ICID_FLV_BRK_HI 12
`define ICID_FLV_BRK_LO 11
`define ICID_FLV_RANGE 10
`define ICID_FLV_S2ATTR 8
`define ICID_FLV_PARTMON 7
`define ICID_FLV_PASID 5
`define ICID_FLV_HWATTR 3
`define ICID_FLV_HAD 2
`define ICID_BRK_L1 2'h1
`define ICID_BRK_L2 2'h2

// ==========================================================================
// granule_address_size_id fields
`define ICID_GAS_STALL_HI 31
`define ICID_GAS_STALL_LO 16
`define ICID_GAS_VEXT_HI 11
`define ICID_GAS_VEXT_LO 10
`define ICID_GAS_G64 6
`define ICID_GAS_G16 5
`define ICID_GAS_G4 4
`define ICID_GAS_OSIZE_HI 2
`define ICID_GAS_OSIZE_LO 0
`define ICID_VEXT_52 2'h1
`define ICID_OSIZE_52 3'h6
`define ICID_OSIZE_RSVD 3'h7

`endif

// *** verilog/icid_pkg.sv ***
// Types shared by the capability identification bank.
package icid_pkg;
  // ==========================================================================
  // Register selector
  typedef enum {ICID_SEL_NONE, ICID_SEL_TQS, ICID_SEL_VPO, ICID_SEL_FLV, ICID_SEL_IMP,
    ICID_SEL_GAS} icid_sel_t;
  typedef logic [31:0] icid_word_t;
endpackage : icid_pkg

// *** verif/icid_bank_tb.sv ***
// Self-checking APB bench for the capability identification bank.
`timescale 1ns/1ps
`default_nettype none

module icid_bank_tb;
  // ==========================================================================
  // Stimulus, observation and bookkeeping
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, stall_room, err;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] pstrb;
  logic [15:0] stall_count, v;
  logic [31:0] w [5];
  int n_mismatch = 0;
  int n_compared = 0;
  localparam logic [15:0] LIM = 16'h0005;
  localparam logic [31:0] IMPL = 32'h5a5a_0001; // Arbitrary value, no maker meaning
  // Illegal settings on purpose, so the clamps show at the ports
  localparam logic P_TABLES = 1'b1, P_RELATIVE = 1'b1, P_MEMTYPE = 1'b1, P_S2ATTR = 1'b1;
  localparam logic P_PAGEREQ = 1'b1, P_PASID = 1'b1, P_HWATTR = 1'b1, P_DESCDIS = 1'b0;
  localparam logic P_G64 = 1'b0, P_G4 = 1'b0, P_TT32 = 1'b1;
  localparam logic [4:0] P_CMDQ = 5'h1f, P_EVTQ = 5'h05, P_PRQ = 5'h14, P_SSID = 5'h1f;
  localparam logic [5:0] P_SID = 6'h3f;
  localparam logic [9:0] P_VOFS = 10'h3ff;
  localparam logic [1:0] P_BRK = 2'h3, P_VEXT = 2'h1;
  localparam logic [2:0] P_OSIZE = 3'h7;

  icid_bank #(.TABLES_FIXED(P_TABLES), .RELATIVE_BASE(P_RELATIVE), .MEMTYPE_OVR(P_MEMTYPE),
    .CMDQ_LOG(P_CMDQ), .EVTQ_LOG(P_EVTQ), .PRQ_LOG(P_PRQ), .SSID_W(P_SSID), .SID_W(P_SID),
    .VPAGE_OFS(P_VOFS), .BREAK_LEVEL(P_BRK), .S2_ATTR(P_S2ATTR), .PAGE_REQ(P_PAGEREQ),
    .PASID_USE(P_PASID), .PAGE_HWATTR(P_HWATTR), .DESC_DISABLE(P_DESCDIS), .IMPL_WORD(IMPL),
    .STALL_LIMIT(LIM), .VIRT_EXT(P_VEXT), .G64(P_G64), .G4(P_G4), .TT32(P_TT32),
    .OUT_SIZE(P_OSIZE)) i_dut (
    .CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .STALL_COUNT(stall_count), .STALL_ROOM(stall_room));

  // ==========================================================================
  // Expected words and shared tasks
  function automatic logic [5:0] sat(input logic [5:0] x, input logic [5:0] m);
    return (x > m) ? m : x;
  endfunction : sat

  function automatic logic [31:0] expect_word(input logic [11:0] ad);
    logic [5:0] c, e, p, s, d;
    logic [1:0] bk, vx;
    logic [2:0] os;
    c = sat({1'b0, P_CMDQ}, 6'h13);
    e = sat({1'b0, P_EVTQ}, 6'h13);
    p = sat({1'b0, P_PRQ}, 6'h13);
    s = sat({1'b0, P_SSID}, 6'h14);
    d = sat(P_SID, 6'h20);
    bk = (P_BRK > 2'h2) ? 2'h2 : P_BRK;
    vx = (P_VEXT > 2'h1) ? 2'h1 : P_VEXT;
    os = (P_OSIZE == 3'h7) ? 3'h6 : P_OSIZE;
    case (ad)
      12'h004: return {1'b0, P_TABLES, 1'b0, P_RELATIVE & P_TABLES, P_MEMTYPE, 1'b0, c[4:0],
        e[4:0], p[4:0], s[4:0], d};
      12'h00c: return {19'h0, bk, 1'b1, 1'b0, P_S2ATTR, 2'b00, P_PASID & P_PAGEREQ & (s != 6'h00),
        1'b0, P_HWATTR, P_HWATTR | P_DESCDIS, 2'b00};
      12'h010: return IMPL;
      12'h014: return {LIM, 4'h0, vx, 3'h0, P_G64 | (vx == 2'h1) | (os == 3'h6), 1'b0,
        P_G4 | P_TT32, 1'b0, os};
      default: return 32'h0000_0000;
    endcase
  endfunction : expect_word

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Master holds the request until pready is sampled high, then drops penable
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    pstrb <= 4'($random(seed));
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    // Zero wait states: ready stands at the first access edge
    chk(n, 1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask : apb

  task automatic idle;
    psel <= 1'b0;
    @(posedge clock);
  endtask : idle

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // A few hundred cycles at most are needed; far more means a hang
  initial
  begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    stall_count = 16'h0000;
    seed = 32'h1222ff61;
    repeat (20) @(posedge clock);
    chk(prdata, 32'h0000_0000);
    chk({pready, pslverr, stall_room}, 3'h0);
    rstn <= 1'b1;
    @(posedge clock);
    // Back-to-back reads of every register, then field by field
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, 12'h004 + 12'(4 * k), 32'h0000_0000);
      w[k] = rd;
      chk(rd, expect_word(12'h004 + 12'(4 * k)));
      chk(err, 1'b0);
    end
    idle();
    chk(w[0][30], 1'b1);
    chk(w[0][29], 1'b0);
    chk(w[0][28], 1'b1);
    chk(w[0][27:26], 2'h2);
    chk(w[0][25:21], 5'h13);
    chk(w[0][20:16], 5'h05);
    chk(w[0][15:11], 5'h13);
    chk(w[0][10:6], 5'h14);
    chk(w[0][5:0], 6'h20);
    chk(w[1][9:0], 10'h000);
    chk(w[2][12:11], 2'h2);
    chk(w[2][10], 1'b1);
    chk(w[2][8], 1'b1);
    chk(w[2][7], 1'b0);
    chk(w[2][5], 1'b1);
    chk(w[2][3:2], 2'h3);
    chk(w[2][2], 1'b1);
    chk(w[4][31:16], LIM);
    chk(w[4][11:10], 2'h1);
    chk(w[4][6:4], 3'h5);
    chk(w[4][2:0], 3'h6);
    $display("test of register contents done");
    // Random writes to every register must leave them as they were
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, 12'h004 + 12'(4 * k), $random(seed));
      chk(err, 1'b0);
      chk(rd, 32'h0000_0000);
    end
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, 12'h004 + 12'(4 * k), 32'h0000_0000);
      chk(rd, expect_word(12'h004 + 12'(4 * k)));
    end
    idle();
    $display("test of ignored writes done");
    // Unmapped places answer with an error and zero data
    for (int k = 0; k < 12; k++)
    begin
      a = 12'($random(seed)) & 12'hffc;
      if (k == 0)
        a = 12'h000;
      if (a > 12'h000 && a < 12'h018)
        a = 12'h018;
      apb(k[0], a, $random(seed));
      chk(rd, 32'h0000_0000);
      chk(err, 1'b1);
    end
    idle();
    $display("test of unmapped places done");
    // Stall admission around the limit, plus the full-scale count
    for (int k = 0; k < 30; k++)
    begin
      v = 16'({$random(seed)} % 12);
      if (k == 0)
        v = 16'hffff;
      stall_count <= v;
      @(posedge clock);
      @(negedge clock);
      chk(stall_room, v < LIM);
      @(posedge clock);
    end
    $display("test of stall limit done");
    // Reset in mid-run clears the outputs and keeps the contents
    rstn <= 1'b0;
    @(negedge clock);
    chk({pready, pslverr, stall_room}, 3'h0);
    chk(prdata, 32'h0000_0000);
    @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, 12'h004 + 12'(4 * k), 32'h0000_0000);
      chk(rd, expect_word(12'h004 + 12'(4 * k)));
    end
    idle();
    $display("test of second reset done");
    test_done();
  end
endmodule : icid_bank_tb

`default_nettype wire
